/* File: inc/ssar_pkg.sv */
// Purpose: shared constants and types of the serial sar readout block
// Assumes: frame is 16 serial clock falling edges long
// Notes:   variants of 12, 10 and 8 result bits share one frame layout
package ssar_pkg;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS  = 16;
  localparam int          LEAD_ZEROS  = 4;
  localparam int          MAX_RES     = 12;
  localparam int          CNT_W       = 5;
  localparam logic [4:0]  CNT_RST     = 5'h00;
  localparam logic [4:0]  CNT_LAST    = 5'h10;
  localparam logic        TRACK_RST   = 1'b1;
  localparam int          SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSAR_PH_LEAD  = 2'b00,
    SSAR_PH_CONV  = 2'b01,
    SSAR_PH_TRAIL = 2'b10,
    SSAR_PH_DONE  = 2'b11
  } ssar_phase_t;

  typedef struct packed {
    logic               tracking;
    logic [MAX_RES-1:0] code;
  } ssar_result_t;
endpackage

/* File: design/ssar_cdc_rx.sv */
// Purpose: receives a word from the serial clock domain by toggle handshake
// Assumes: word is stable for well over three sys_clk cycles after a toggle
// Notes:   first sync flop feeds only the second
`timescale 1ns/1ps
module ssar_cdc_rx
  import ssar_pkg::*;
#(
  parameter int W = 13
) (
  input  wire logic         sys_clk_i,
  input  wire logic         srst_i,
  input  wire logic         tog_i,
  input  wire logic [W-1:0] data_i,
  output logic      [W-1:0] data_o,
  output logic              valid_o
);
  logic         tog_s1_r;
  logic         tog_s2_r;
  logic         tog_s3_r;
  logic         tog_s4_r;
  logic [W-1:0] data_s1_r;
  logic [W-1:0] data_s2_r;
  // one stage of margin so the word flops hold the new value when it is taken
  wire  logic   event_w = tog_s3_r ^ tog_s4_r;

  if (W < 1) begin : g_bad_w
    $error("width must be positive");
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
      tog_s4_r <= 1'b0;
    end else begin
      tog_s1_r <= tog_i;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
      tog_s4_r <= tog_s3_r;
    end
  end

  // data bus is quiet while the toggle travels
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      data_s1_r <= '0;
      data_s2_r <= '0;
      data_o    <= '0;
      valid_o   <= 1'b0;
    end else begin
      data_s1_r <= data_i;
      data_s2_r <= data_s1_r;
      valid_o   <= event_w;
      if (event_w) begin
        data_o <= data_s2_r;
      end
    end
  end
endmodule // ssar_cdc_rx

/* File: design/ssar_readout.sv */
// Purpose: conversion control and serial readout of a sar converter
// Assumes: host frames with select low and gives 16 serial clock falls
// Notes:   the serial clock steps the conversion; select high ends a frame
//
// How it works
// [RQ1] the serial clock is the only clock that steps the conversion and the shift-out.
// [RQ2] each new frame bit appears on the data line at a serial clock falling edge.
// [RQ3] the 12-bit variant sends four zeros then twelve result bits, msb first.
// [RQ4] the 10-bit variant sends four zeros, ten result bits msb first, then two zeros.
// [RQ5] the 8-bit variant sends four zeros, eight result bits msb first, then four zeros.
// [RQ6] select driven low starts the conversion and frames the transfer.
// [RQ7] at end of conversion the sampling stage returns to tracking the input.
// [RQ8] the result is straight binary, all zeros at the bottom, all ones at full scale.
// [RQ9] after the last bit has gone out on a falling edge the data line is released.
// [RQ10] the host gives sixteen falling edges while select is low; the bench also runs one frame of 18 edges and one cut off after 8.
`timescale 1ns/1ps
module ssar_readout
  import ssar_pkg::*;
#(
  parameter int RES_BITS = 12
) (
  input  wire logic               sys_clk_i,
  input  wire logic               srst_i,
  input  wire logic               serial_clk_i,
  input  wire logic               select_n_i,
  input  wire logic [MAX_RES-1:0] analog_sample_input_i,
  output logic                    serial_result_out_o,
  output logic                    serial_result_out_oe_o,
  output logic [MAX_RES-1:0]      result_code_o,
  output logic                    result_valid_o,
  output logic                    sample_tracking_o
);
  localparam logic [4:0] CONV_FIRST = 5'(LEAD_ZEROS);
  localparam logic [4:0] CONV_LAST  = 5'(LEAD_ZEROS + RES_BITS - 1);
  // only the low RES_BITS of the input word take part in a conversion
  localparam logic [MAX_RES-1:0] RES_MASK = MAX_RES'((13'h0001 << RES_BITS) - 13'h0001);

  if (RES_BITS != 12 && RES_BITS != 10 && RES_BITS != 8) begin : g_bad_res
    $error("unsupported resolution");
  end

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic ssar_phase_t frame_phase(input logic [CNT_W-1:0] cnt);
    if (cnt < CONV_FIRST) frame_phase = SSAR_PH_LEAD;
    else if (cnt <= CONV_LAST) frame_phase = SSAR_PH_CONV;
    else if (cnt < CNT_LAST) frame_phase = SSAR_PH_TRAIL;
    else frame_phase = SSAR_PH_DONE;
  endfunction

  function automatic logic [MAX_RES-1:0] bit_weight(input logic [CNT_W-1:0] cnt);
    logic [CNT_W-1:0] idx;
    idx = CNT_W'(CONV_LAST - cnt);
    bit_weight = MAX_RES'(1) << idx;
  endfunction

  // ----------------------------------------------------------------
  // serial clock domain; counter, data, done and sar flops cleared, tracking flop set while select is high
  // ----------------------------------------------------------------
  logic [CNT_W-1:0]   cnt_r;
  logic [CNT_W-1:0]   cnt_nxt;
  logic [MAX_RES-1:0] ain_s1_r;
  logic [MAX_RES-1:0] ain_s2_r;
  logic [MAX_RES-1:0] sample_r;
  logic [MAX_RES-1:0] sar_r;
  logic [MAX_RES-1:0] sar_nxt;
  logic [MAX_RES-1:0] hold_r = '0;
  logic               data_r;
  logic               data_nxt;
  logic               done_r;
  logic               tracking_r;
  logic               tog_r = 1'b0;
  ssar_phase_t        phase_nxt;

  wire logic [MAX_RES-1:0] trial_w   = sar_r | bit_weight(cnt_nxt);
  wire logic               decide_w  = (sample_r >= trial_w);
  wire logic               conv_w    = (phase_nxt == SSAR_PH_CONV);
  wire logic               finish_w  = conv_w && (cnt_nxt == CONV_LAST);

  assign cnt_nxt   = (cnt_r == CNT_LAST) ? cnt_r : CNT_W'(cnt_r + 5'h01);
  assign phase_nxt = frame_phase(cnt_nxt);
  assign sar_nxt   = (conv_w && decide_w) ? trial_w : sar_r;

  // zeros outside the conversion phase pad the frame
  always_comb begin
    case (phase_nxt)
      SSAR_PH_LEAD:  data_nxt = 1'b0;              // [RQ3] [RQ4] [RQ5]
      SSAR_PH_CONV:  data_nxt = decide_w;          // [RQ3] [RQ4] [RQ5] [RQ8]
      SSAR_PH_TRAIL: data_nxt = 1'b0;              // [RQ4] [RQ5]
      SSAR_PH_DONE:  data_nxt = 1'b0;
      default:       data_nxt = 1'b0;
    endcase
  end

  // input word passes two flops on the serial clock
  always_ff @(negedge serial_clk_i) begin
    ain_s1_r <= analog_sample_input_i;
    ain_s2_r <= ain_s1_r;
  end

  always_ff @(negedge serial_clk_i or posedge select_n_i) begin
    if (select_n_i) begin
      cnt_r      <= CNT_RST;                       // [RQ6]
      data_r     <= 1'b0;
      done_r     <= 1'b0;
      sar_r      <= '0;
      tracking_r <= TRACK_RST;
    end else begin
      cnt_r  <= cnt_nxt;                           // [RQ1]
      data_r <= data_nxt;                          // [RQ2]
      sar_r  <= sar_nxt;                           // [RQ1]
      if (cnt_nxt == CNT_LAST) begin
        done_r <= 1'b1;                            // [RQ9]
      end
      if (cnt_r == CNT_RST) begin
        tracking_r <= 1'b0;                        // [RQ6]
      end else if (finish_w) begin
        tracking_r <= 1'b1;                        // [RQ7]
      end
    end
  end

  // sample and finished code live across frames
  always_ff @(negedge serial_clk_i) begin
    if (!select_n_i && cnt_r == CNT_RST) begin
      sample_r <= ain_s2_r & RES_MASK;
    end
    if (!select_n_i && finish_w) begin
      hold_r <= sar_nxt;                           // [RQ8]
      tog_r  <= ~tog_r;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  assign serial_result_out_o    = data_r;
  assign serial_result_out_oe_o = !select_n_i && !done_r; // [RQ6] [RQ9]

  // ----------------------------------------------------------------
  // system clock side
  // ----------------------------------------------------------------
  ssar_result_t res_w;
  ssar_result_t res_sys;
  logic         trk_s1_r;
  logic         trk_s2_r;

  assign res_w.tracking = 1'b1;
  assign res_w.code     = hold_r;

  ssar_cdc_rx #(
    .W ($bits(ssar_result_t))
  ) u_cdc (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .tog_i     (tog_r),
    .data_i    (res_w),
    .data_o    (res_sys),
    .valid_o   (result_valid_o)
  );

  assign result_code_o = res_sys.code;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      trk_s1_r          <= TRACK_RST;
      trk_s2_r          <= TRACK_RST;
      sample_tracking_o <= TRACK_RST;
    end else begin
      trk_s1_r          <= tracking_r;
      trk_s2_r          <= trk_s1_r;
      sample_tracking_o <= trk_s2_r;              // [RQ7]
    end
  end

  // ----------------------------------------------------------------
  // checks on the serial clock domain
  // ----------------------------------------------------------------
  property p_step;
    @(negedge serial_clk_i) disable iff (select_n_i)
    cnt_r < CNT_LAST |=> cnt_r == $past(cnt_r) + 5'h01;
  endproperty
  a_step: assert property (p_step) else $error("edge count did not step"); // [RQ1]

  property p_lead;
    @(negedge serial_clk_i) disable iff (select_n_i)
    cnt_r < CONV_FIRST |-> !data_r;
  endproperty
  a_lead: assert property (p_lead) else $error("leading bit not zero"); // [RQ3]

  property p_trail;
    @(negedge serial_clk_i) disable iff (select_n_i)
    (cnt_r > CONV_LAST) |-> !data_r;
  endproperty
  a_trail: assert property (p_trail) else $error("trailing bit not zero"); // [RQ4]

  property p_msb;
    @(negedge serial_clk_i) disable iff (select_n_i)
    cnt_r == CONV_FIRST |-> data_r == (sample_r >= (MAX_RES'(1) << (RES_BITS - 1)));
  endproperty
  a_msb: assert property (p_msb) else $error("msb decision wrong"); // [RQ2]

  property p_code;
    @(negedge serial_clk_i) disable iff (select_n_i)
    cnt_r == CONV_LAST |-> sar_r == sample_r;
  endproperty
  a_code: assert property (p_code) else $error("final code differs from sample"); // [RQ8]

  property p_bits;
    @(negedge serial_clk_i) disable iff (select_n_i)
    (cnt_r >= CONV_FIRST && cnt_r <= CONV_LAST) |-> data_r == |(sar_r & bit_weight(cnt_r));
  endproperty
  a_bits: assert property (p_bits) else $error("shifted bit differs from decision"); // [RQ5]

  property p_track;
    @(negedge serial_clk_i) disable iff (select_n_i)
    cnt_r == CONV_LAST |-> tracking_r ##1 tracking_r;
  endproperty
  a_track: assert property (p_track) else $error("no return to tracking"); // [RQ7]

  property p_hold;
    @(negedge serial_clk_i) disable iff (select_n_i)
    (cnt_r >= 5'h01 && cnt_r < CONV_LAST) |-> !tracking_r;
  endproperty
  a_hold: assert property (p_hold) else $error("tracking during conversion"); // [RQ6]

  property p_release;
    @(negedge serial_clk_i) disable iff (select_n_i)
    cnt_r == 5'h0f |=> !serial_result_out_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("line not released"); // [RQ9]
endmodule // ssar_readout

/* File: tb/ssar_host_model.sv */
// Purpose: host serial port that frames and clocks the readout block
// Assumes: serial clock idles high and runs only around frames
// Notes:   three data lines, one per variant, share select and clock
`timescale 1ns/1ps
module ssar_host_model (
  input  wire logic [2:0] data_i,
  input  wire logic [2:0] oe_i,
  output logic            serial_clk_o,
  output logic            select_n_o
);
  localparam time HALF = 24;
  logic [15:0] rx [3];
  logic [2:0]  rel;
  logic [2:0]  oe_at_start;
  // released line floats to the inverse of the bit on the data input
  wire  logic [2:0] line_w = data_i ^ ~oe_i;

  // a rising select at start clears the link side
  initial begin
    serial_clk_o = 1'b1;
    select_n_o   = 1'b0;
    #HALF select_n_o = 1'b1;
  end

  // ----------------------------------------------------------------
  // one frame: sync preamble, select, edges, release
  // ----------------------------------------------------------------
  task automatic frame(input int nedges, input int abort_at);
    int n;
    int g;
    repeat (2) begin
      #HALF serial_clk_o = 1'b0;
      #HALF serial_clk_o = 1'b1;
    end
    #HALF select_n_o = 1'b0;
    #HALF;
    oe_at_start = oe_i;
    rel = 3'b111;
    for (g = 0; g < 3; g++) rx[g][15] = line_w[g];
    for (n = 1; n <= nedges; n++) begin
      serial_clk_o = 1'b0;
      #HALF serial_clk_o = 1'b1;
      if (n < 16) begin
        for (g = 0; g < 3; g++) rx[g][15-n] = line_w[g];
      end else begin
        rel = rel & ~oe_i;
      end
      if (n == abort_at) break;
      #HALF;
    end
    #HALF select_n_o = 1'b1;
  endtask
endmodule // ssar_host_model

/* File: tb/test_serial_sar_adc_readout.sv */
// Purpose: self-checking bench of the serial sar readout, all three widths
// Assumes: host model paces the link at 48 ns, sys clock 40 ns
// Notes:   random codes from a fixed seed plus corner frames
`timescale 1ns/1ps
module test_serial_sar_adc_readout;
  import ssar_pkg::*;
  logic               sys_clk_i;
  logic               srst_i;
  logic               serial_clk;
  logic               select_n;
  logic [MAX_RES-1:0] analog_r;
  logic [2:0]         sdo;
  logic [2:0]         oe;
  logic [2:0]         valid;
  logic [2:0]         trk;
  logic [2:0][MAX_RES-1:0] code;
  int                 vcnt [3] = '{0, 0, 0};
  int                 tlow [3] = '{0, 0, 0};
  int                 miscompares = 0;
  int                 comparisons = 0;
  int                 cycles = 0;

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  ssar_host_model i_host (.data_i(sdo), .oe_i(oe), .serial_clk_o(serial_clk), .select_n_o(select_n));

  // ----------------------------------------------------------------
  // one readout per variant: 12, 10 and 8 bits
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 3; g++) begin : g_var
    ssar_readout #(.RES_BITS(MAX_RES-2*g)) i_dut (
      .sys_clk_i(sys_clk_i), .srst_i(srst_i), .serial_clk_i(serial_clk), .select_n_i(select_n),
      .analog_sample_input_i(analog_r), .serial_result_out_o(sdo[g]), .serial_result_out_oe_o(oe[g]),
      .result_code_o(code[g]), .result_valid_o(valid[g]), .sample_tracking_o(trk[g]));
    always @(posedge sys_clk_i) begin
      if (valid[g] === 1'b1) vcnt[g] <= vcnt[g] + 1;
      if (select_n === 1'b0 && trk[g] === 1'b0) tlow[g] <= tlow[g] + 1;
    end
  end

  // ----------------------------------------------------------------
  // expectations and compares
  // ----------------------------------------------------------------
  function automatic logic [15:0] exp_frame(input int res, input logic [11:0] a);
    logic [11:0] c;
    c = a & ((12'h001 << res) - 12'h001);
    return {4'h0, c} << (12 - res);
  endfunction

  task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", what, e, s);
    end
  endtask

  task automatic chk_bit(input string what, input logic e, input logic s);
    chk_word(what, {15'h0000, e}, {15'h0000, s});
  endtask

  task automatic test_done();
    $display("counts: comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic run_frame(input logic [11:0] a, input int nedges, input int abort_at);
    int v0 [3];
    int t0 [3];
    int g;
    int res;
    @(posedge sys_clk_i) analog_r <= a;
    repeat (2) @(posedge sys_clk_i);
    for (g = 0; g < 3; g++) begin
      v0[g] = vcnt[g];
      t0[g] = tlow[g];
    end
    i_host.frame(nedges, abort_at);
    repeat (8) @(posedge sys_clk_i);
    for (g = 0; g < 3; g++) begin
      res = 12 - 2 * g;
      if (abort_at != 0) begin
        chk_word("valid count", 16'(v0[g]), 16'(vcnt[g]));
        chk_bit("drive enable", 1'b0, oe[g]);
      end else begin
        chk_word("frame", exp_frame(res, a), i_host.rx[g]);
        chk_word("code", exp_frame(res, a) >> (12 - res), {4'h0, code[g]});
        chk_word("valid count", 16'(v0[g] + 1), 16'(vcnt[g]));
        chk_bit("drive at select", 1'b1, i_host.oe_at_start[g]);
        chk_bit("released", 1'b1, i_host.rel[g]);
        chk_bit("tracking dropped", 1'b1, tlow[g] > t0[g]);
        chk_bit("tracking back", 1'b1, trk[g]);
      end
    end
    $display("test done: code %h edges %0d abort %0d", a, nedges, abort_at);
  endtask

  // ----------------------------------------------------------------
  // timeout and main sequence
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    srst_i   = 1'b1;
    analog_r = 12'h000;
    void'($urandom(97783));
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    run_frame(12'h000, 16, 0);
    run_frame(12'hfff, 16, 0);
    run_frame(12'ha5c, 18, 0);
    run_frame(12'h3c3, 16, 8);
    run_frame(12'h801, 16, 0);
    for (int i = 0; i < 10; i++) begin
      run_frame(12'($urandom), 16, 0);
    end
    test_done();
  end
endmodule // test_serial_sar_adc_readout
